// ---- bench/pcm_pad_model.sv ----
// Purpose: pads seen from outside the block
// Assumes: board level where the block does not drive
// Notes:   driven pad reads back its own level
`timescale 1ns/1ps
`default_nettype none
module pcm_pad_model (
  input  wire logic [pcm_pkg::PCM_NPIN-1:0] ext_lvl, // board level
  input  wire logic [pcm_pkg::PCM_NPIN-1:0] pad_out, // block level
  input  wire logic [pcm_pkg::PCM_NPIN-1:0] pad_oe,  // block drive on
  output logic      [pcm_pkg::PCM_NPIN-1:0] pad_in   // pad level
);
  import pcm_pkg::*;
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_lvl);
endmodule
`default_nettype wire

// ---- bench/pcm_top_properties.sv ----
// Purpose: bus handshake and pad routing checks on pcm_top
// Assumes: one clock, async active-low reset
// Notes:   bound to pcm_top, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module pcm_top_properties (
  input wire logic                                 clk,             // clock
  input wire logic                                 reset_n,         // reset
  input wire logic                                 arvalid,         // read addr valid
  input wire logic                                 arready,         // read addr ready
  input wire logic                                 rvalid,          // read valid
  input wire logic                                 rready,          // read ready
  input wire logic [pcm_pkg::PCM_DW-1:0]           rdata,           // read data
  input wire logic                                 bvalid,          // resp valid
  input wire logic                                 bready,          // resp ready
  input wire logic                                 analog_sel,      // analog mode
  input wire logic [pcm_pkg::PCM_NPIN-1:0]         pad_oe,          // driver on
  input wire logic [pcm_pkg::PCM_NPIN-1:0]         pad_input_en,    // input on
  input wire logic [pcm_pkg::PCM_NPIN-1:0]         gpio_in,         // gpio data
  input wire logic [pcm_pkg::PCM_NPIN-1:0][2:0]    drive_level,     // drive code
  input wire logic [pcm_pkg::PCM_NIRQ-1:0][4:0]    function_select, // routing
  input wire logic [pcm_pkg::PCM_NIRQ-1:0][31:0]   periph_rx_sel,   // routed code
  input wire logic [pcm_pkg::PCM_NIRQ-1:0]         irq_req          // requests
);
  import pcm_pkg::*;
  // ==========================================================================
  // bus
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_rd_taken;
    arvalid && arready;
  endsequence
  sequence s_rd_wait;
    rvalid && !rready;
  endsequence
  a_read_answer: assert property (s_rd_taken |=> rvalid)
    else $error("read not answered");
  a_read_holds: assert property (s_rd_wait |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_ar_refused: assert property (rvalid |-> !arready)
    else $error("address taken during read");
  a_resp_holds: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped");
  // ==========================================================================
  // pads
  a_reset_values: assert property ($rose(reset_n) |-> drive_level[0] == 3'h1 && analog_sel && irq_req == '0)
    else $error("reset values wrong");
  a_analog_quiet: assert property (analog_sel |-> !pad_oe[6])
    else $error("analog pad driven");
  a_oe_listed: assert property (!PCM_LEGAL[1][function_select[1]] |-> !pad_oe[1])
    else $error("unlisted code drives pad");
  a_sel_onehot: assert property ($onehot0(periph_rx_sel[1]))
    else $error("routing not one-hot");
  a_gpin_gate: assert property (gpio_in[1] |-> $past(pad_input_en[1]) && $past(function_select[1]) == 5'h0)
    else $error("gpio input not gated");
endmodule
bind pcm_top pcm_top_properties pcm_top_properties_i (.*);
`default_nettype wire

// ---- bench/pcm_top_tb.sv ----
// Purpose: self-checking bench of pcm_top
// Assumes: pcm_pad_model on the pads
// Notes:   pin38 slot carries the trigger tests
`timescale 1ns/1ps
`default_nettype none
module pcm_top_tb;
  import pcm_pkg::*;
  logic clk = 0, reset_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, analog_sel, en, mk, idle;
  logic [2:0] m;
  logic [PCM_AW-1:0] awaddr = '0, araddr = '0;
  logic [PCM_DW-1:0] wdata = '0, rdata, d, g;
  logic [PCM_SW-1:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp;
  logic [PCM_NPIN-1:0] ext_lvl = '0, gpio_out = '0, pad_in, pad_out, pad_oe, gpio_in;
  logic [PCM_NPIN-1:0] pad_input_en, pullup_50k_en, pulldown_100k_en;
  logic [PCM_NPIN-1:0] pullup_10k_en, schmitt_en;
  logic [PCM_NPIN-1:0][2:0] drive_level;
  logic [PCM_NIRQ-1:0] double_nmos_en, periph_rx, irq_req;
  logic [PCM_NIRQ-1:0][4:0] function_select;
  logic [PCM_NIRQ-1:0][31:0] periph_tx = '0, periph_rx_sel;
  logic [33:0] exp_q[$];
  int bad_count = 0, cmp_count = 0, cyc = 0;
  pcm_top pcm_top_i (.*);
  pcm_pad_model pcm_pad_model_i (.*);
  initial forever #2 clk = ~clk;
  // ==========================================================================
  // checks and verdict
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] v);
    cmp_count++;
    if (v !== e)
    begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, v);
    end
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      print_verdict();
    end
  end
  always @(negedge clk)
    if (rvalid && rready)
      chk("rdata", exp_q.pop_front(), {rresp, rdata});
  // ==========================================================================
  // bus tasks
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] rb;
    @(posedge clk);
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
    do
    begin
      @(negedge clk);
      ta = awready; tw = wready; tb = bvalid; rb = bresp;
      @(posedge clk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
    end while (!tb);
    bready <= 0;
    chk("bresp", er, rb);
  endtask
  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    logic t;
    exp_q.push_back(e);
    @(posedge clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin @(negedge clk); t = arready; @(posedge clk); end while (!t);
    arvalid <= 0;
    do begin @(negedge clk); t = rvalid; @(posedge clk); end while (!t);
    rready <= 0;
  endtask
  function automatic logic [11:0] off(input int j);
    return j < 6 ? PCM_IRQ_OFF[j] : PCM_OFF_PIN64;
  endfunction
  // ==========================================================================
  // scenarios
  initial
  begin
    void'($urandom(32'h00a5));
    repeat (4) @(posedge clk);
    reset_n <= 1;
    for (int j = 0; j < 7; j++)
    begin
      d = $urandom;
      if (j == 1) d[6:0] = 7'h5f;
      d[PCM_IEN_IRQ_BIT] = 1'b0; // no stray pending from random setups
      gpio_out <= d[6:0];
      periph_tx <= {6{d}};
      rd(off(j), {2'h0, j < 6 ? PCM_IRQ_RST : PCM_ANA_RST});
      wr(off(j), d, 2'h0);
      rd(off(j), {2'h0, d & (j < 6 ? PCM_IRQ_WMASK : PCM_ANA_WMASK)});
      g = {pullup_50k_en[j], pulldown_100k_en[j], pullup_10k_en[j], pad_input_en[j]};
      chk("pad_ctl", {d[11], d[9:7], d[5], d[14:12]}, {g[3:0], schmitt_en[j], drive_level[j]});
      g = {d[15], d[4:0], d[6] & PCM_LEGAL[j % 6][d[4:0]]};
      if (j < 6) chk("fsel", g, {double_nmos_en[j], function_select[j], pad_oe[j]});
      g = j < 6 ? (d[4:0] == 0 ? d[j] : PCM_LEGAL[j % 6][d[4:0]] & d[d[4:0]]) : ~d[4] & d[6];
      chk("pad_out", g[0], pad_out[j]);
    end
    wstrb <= 4'h1;
    wr(PCM_OFF_PIN64, 32'hffff_ffff, 2'h0);
    wstrb <= 4'hf;
    rd(PCM_OFF_PIN64, {2'h0, (d | 32'hff) & PCM_ANA_WMASK});
    wr(12'h00c, d, PCM_RESP_SLVERR);
    rd(12'h00c, {PCM_RESP_SLVERR, 32'h0});
    for (int i = 0; i < 7; i++)
    begin
      m = (i < 5) ? i[2:0] : 3'h0;
      en = (i != 5);
      mk = (i != 6);
      idle = (m == PCM_TRIG_FALL || m == PCM_TRIG_LOW);
      ext_lvl[1] <= idle;
      repeat (4) @(posedge clk);
      wr(PCM_OFF_PIN38, {6'h0, mk, 1'b0, m, en, 12'h0, 8'h80}, 2'h0);
      wr(PCM_OFF_PEND, 32'h3f, 2'h0);
      ext_lvl[1] <= !idle;
      repeat (6) @(negedge clk);
      chk("irq_req", en & mk, irq_req[1]);
      rd(PCM_OFF_PEND, {32'h0, en, 1'b0});
    end
    print_verdict();
  end
endmodule
`default_nettype wire

// ---- verilog/pcm_pkg.sv ----
// Purpose: shared constants of the pad control and trigger block
// Assumes: 32-bit AXI4-Lite register bus, 12-bit byte addresses
// Notes:   pin slots 0..5 carry trigger logic, slot 6 is the analog-capable pad
`default_nettype none
package pcm_pkg;

  // ==========================================================================
  // sizes
  localparam int PCM_NIRQ = 6;
  localparam int PCM_NPIN = 7;
  localparam int PCM_AW   = 12;
  localparam int PCM_DW   = 32;
  localparam int PCM_SW   = 4;
  localparam int PCM_ANA  = 6;

  // ==========================================================================
  // register byte offsets
  localparam logic [PCM_AW-1:0] PCM_OFF_PIN33 = 12'h088;
  localparam logic [PCM_AW-1:0] PCM_OFF_PIN38 = 12'h09c;
  localparam logic [PCM_AW-1:0] PCM_OFF_PIN39 = 12'h0a0;
  localparam logic [PCM_AW-1:0] PCM_OFF_PIN43 = 12'h0b0;
  localparam logic [PCM_AW-1:0] PCM_OFF_PIN55 = 12'h0e0;
  localparam logic [PCM_AW-1:0] PCM_OFF_PIN56 = 12'h0e4;
  localparam logic [PCM_AW-1:0] PCM_OFF_PIN64 = 12'h104;
  localparam logic [PCM_AW-1:0] PCM_OFF_PEND  = 12'h300;
  localparam logic [PCM_AW-1:0] PCM_OFF_LEVEL = 12'h304;
  localparam logic [PCM_AW-1:0] PCM_IRQ_OFF [PCM_NIRQ] = '{PCM_OFF_PIN33, PCM_OFF_PIN38,
    PCM_OFF_PIN39, PCM_OFF_PIN43, PCM_OFF_PIN55, PCM_OFF_PIN56};

  // ==========================================================================
  // field positions
  localparam int PCM_FSEL_LSB = 0;
  localparam int PCM_FSEL_W   = 5;
  localparam int PCM_ANA_BIT  = 4;
  localparam int PCM_SMT_BIT  = 5;
  localparam int PCM_OEN_BIT  = 6;
  localparam int PCM_IEN_BIT  = 7;
  localparam int PCM_PU10_BIT = 8;
  localparam int PCM_PD100_BIT = 9;
  localparam int PCM_PU50_BIT = 11;
  localparam int PCM_DRV_LSB  = 12;
  localparam int PCM_DRV_W    = 3;
  localparam int PCM_DNM_BIT  = 15;
  localparam int PCM_IEN_IRQ_BIT = 20;
  localparam int PCM_TRIG_LSB = 21;
  localparam int PCM_TRIG_W   = 3;
  localparam int PCM_MSK_BIT  = 25;

  // ==========================================================================
  // writable bits and reset values
  localparam logic [PCM_DW-1:0] PCM_IRQ_WMASK = 32'h02f0_fbff;
  localparam logic [PCM_DW-1:0] PCM_ANA_WMASK = 32'h0000_7bf0;
  localparam logic [PCM_DW-1:0] PCM_IRQ_RST   = 32'h0000_1000;
  localparam logic [PCM_DW-1:0] PCM_ANA_RST   = 32'h0000_1010;

  // ==========================================================================
  // trigger mode codes
  localparam logic [PCM_TRIG_W-1:0] PCM_TRIG_RISE = 3'h0;
  localparam logic [PCM_TRIG_W-1:0] PCM_TRIG_FALL = 3'h1;
  localparam logic [PCM_TRIG_W-1:0] PCM_TRIG_BOTH = 3'h2;
  localparam logic [PCM_TRIG_W-1:0] PCM_TRIG_HIGH = 3'h3;
  localparam logic [PCM_TRIG_W-1:0] PCM_TRIG_LOW  = 3'h4;

  // ==========================================================================
  // listed function codes per pin, one bit per code, code 0 is plain gpio
  // pin33: 2 display_data_23, 4 card0_data_0, 7 serial_periph1_mosi,
  //   8 serial_periph2_mosi, 12 serial3_receive, 16 pulse_out_ch6, 18 audio_tx1_data_out
  // pin38: 2 display_data_4, 7 flash_port_data_2, 10 serial1_transmit, 16 pulse_out_ch4,
  //   17 audio_tx0_master_clock, 24 pdm_transmit_clock, 25 mic_pair23_clock, 27 key_adc_input_6
  // pin39: 2 display_data_5, 4 card0_clock_1, 7 flash_port_data_3, 10 serial1_receive,
  //   16 pulse_out_ch5, 17 audio_tx0_bit_clock, 24 pdm_transmit_data, 25 mic_pair23_data,
  //   27 key_adc_input_9
  // pin43: 2 display_enable_hsync, 4 card0_data_1, 7 flash_port_data_2,
  //   12 serial3_clear_to_send, 14 two_wire1_clock, 16 pulse_out_ch5, 19 audio_rx0_data_in
  // pin55: 5 card1_data_0, 7 flash_port_data_7, 12 serial3_transmit, 16 pulse_out_ch7,
  //   20 audio_rx1_bit_clock, 27 key_adc_input_9
  // pin56: 5 card1_data_1, 7 flash_port_data_strobe, 12 serial3_receive, 16 pulse_out_ch8,
  //   20 audio_rx1_frame_clock
  localparam logic [PCM_DW-1:0] PCM_LEGAL [PCM_NIRQ] = '{32'h0005_1195, 32'h0b03_0485,
    32'h0b03_0495, 32'h0009_5095, 32'h0811_10a1, 32'h0011_10a1};

  // ==========================================================================
  // bus responses
  localparam logic [1:0] PCM_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PCM_RESP_SLVERR = 2'h2;

endpackage
`default_nettype wire

// ---- verilog/pcm_top.sv ----
// Purpose: pad control registers, function routing and pin trigger logic
// Assumes: AXI4-Lite slave, single clock, pads sampled asynchronously
// Notes:   slots 0..5 are pins 33 38 39 43 55 56, slot 6 is pin 64
//
// Contract
// - three-bit trigger mode at bits 23:21
// - interrupt enable low blocks pending and request
// - interrupt enable high sets pending on event
// - bit 25 gates request to interrupt controller
// - bit 6 enables output driver, resets 0
// - bit 7 enables input path, resets 0
// - drive level field 14:12 resets to 1
// - pull-up 50k, pull-down 100k, pull-up 10k bits
// - bit 15 double nmos option, resets off
// - bit 5 schmitt input, resets off
// - function select 4:0, zero is gpio
// - pin 33 function code map
// - pin 38 function code map
// - pin 39 function code map
// - pin 43 function code map
// - pin 55 function code map
// - pin 56 function code map
// - pin 64 bit 4 analog select, resets 1
`timescale 1ns/1ps
`default_nettype none
module pcm_top (
  input  wire logic                                   clk,           // 250 MHz clock
  input  wire logic                                   reset_n,       // async reset
  input  wire logic [pcm_pkg::PCM_AW-1:0]             awaddr,        // write address
  input  wire logic                                   awvalid,       // write address valid
  output logic                                        awready,       // write address ready
  input  wire logic [pcm_pkg::PCM_DW-1:0]             wdata,         // write data
  input  wire logic [pcm_pkg::PCM_SW-1:0]             wstrb,         // byte strobes
  input  wire logic                                   wvalid,        // write data valid
  output logic                                        wready,        // write data ready
  output logic [1:0]                                  bresp,         // write response
  output logic                                        bvalid,        // write response valid
  input  wire logic                                   bready,        // write response ready
  input  wire logic [pcm_pkg::PCM_AW-1:0]             araddr,        // read address
  input  wire logic                                   arvalid,       // read address valid
  output logic                                        arready,       // read address ready
  output logic [pcm_pkg::PCM_DW-1:0]                  rdata,         // read data
  output logic [1:0]                                  rresp,         // read response
  output logic                                        rvalid,        // read data valid
  input  wire logic                                   rready,        // read data ready
  input  wire logic [pcm_pkg::PCM_NPIN-1:0]           pad_in,        // raw pad levels
  output logic [pcm_pkg::PCM_NPIN-1:0]                pad_out,       // pad output level
  output logic [pcm_pkg::PCM_NPIN-1:0]                pad_oe,        // pad output driver on
  output logic [pcm_pkg::PCM_NPIN-1:0]                pad_input_en,  // pad input path on
  output logic [pcm_pkg::PCM_NPIN-1:0]                pullup_50k_en, // 50k pull-up
  output logic [pcm_pkg::PCM_NPIN-1:0]                pulldown_100k_en, // 100k pull-down
  output logic [pcm_pkg::PCM_NPIN-1:0]                pullup_10k_en, // 10k pull-up
  output logic [pcm_pkg::PCM_NPIN-1:0][2:0]           drive_level,   // drive code
  output logic [pcm_pkg::PCM_NPIN-1:0]                schmitt_en,    // schmitt input
  output logic [pcm_pkg::PCM_NIRQ-1:0]                double_nmos_en, // double nmos
  output logic [pcm_pkg::PCM_NIRQ-1:0][4:0]           function_select, // routing code
  output logic                                        analog_sel,    // pin 64 analog mode
  input  wire logic [pcm_pkg::PCM_NPIN-1:0]           gpio_out,      // gpio output data
  output logic [pcm_pkg::PCM_NPIN-1:0]                gpio_in,       // gpio input data
  input  wire logic [pcm_pkg::PCM_NIRQ-1:0][31:0]     periph_tx,     // peripheral out, by code
  output logic [pcm_pkg::PCM_NIRQ-1:0][31:0]          periph_rx_sel, // one-hot routed code
  output logic [pcm_pkg::PCM_NIRQ-1:0]                periph_rx,     // routed pad level
  output logic [pcm_pkg::PCM_NIRQ-1:0]                irq_req        // to interrupt_controller
);
  import pcm_pkg::*;

  // ==========================================================================
  // state
  logic                 aw_full_q, aw_full_d;
  logic [PCM_AW-1:0]    aw_addr_q, aw_addr_d;
  logic                 w_full_q, w_full_d;
  logic [PCM_DW-1:0]    w_data_q, w_data_d;
  logic [PCM_SW-1:0]    w_strb_q, w_strb_d;
  logic                 bvalid_q, bvalid_d;
  logic [1:0]           bresp_q, bresp_d;
  logic                 rvalid_q, rvalid_d;
  logic [PCM_DW-1:0]    rdata_q, rdata_d;
  logic [1:0]           rresp_q, rresp_d;
  logic [PCM_DW-1:0]    ctl_q [PCM_NIRQ];
  logic [PCM_DW-1:0]    ctl_d [PCM_NIRQ];
  logic [PCM_DW-1:0]    ana_q, ana_d;
  logic [PCM_NIRQ-1:0]  pend_q, pend_d;
  logic [PCM_NPIN-1:0]  sync1_q, sync2_q;
  logic [PCM_NPIN-1:0]  pad_out_q, pad_out_d;
  logic [PCM_NPIN-1:0]  gpio_in_q, gpio_in_d;
  logic [PCM_NIRQ-1:0][31:0] rx_sel_q, rx_sel_d;
  logic [PCM_NIRQ-1:0]  rx_q, rx_d;
  logic [PCM_NIRQ-1:0]  evt;
  logic [PCM_NIRQ-1:0]  legal;
  logic                 do_write;

  function automatic logic [PCM_DW-1:0] merge(input logic [PCM_DW-1:0] old_v,
                                               input logic [PCM_DW-1:0] new_v,
                                               input logic [PCM_SW-1:0] strb);
    logic [PCM_DW-1:0] res;
    res = old_v;
    for (int b = 0; b < PCM_SW; b++)
      if (strb[b])
        res[8*b +: 8] = new_v[8*b +: 8];
    return res;
  endfunction

  // ==========================================================================
  // pad input synchroniser
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= pad_in;
      sync2_q <= sync1_q;
    end
  end

  // ==========================================================================
  // trigger detectors
  pcm_trig_if trig_if [PCM_NIRQ] ();

  for (genvar g = 0; g < PCM_NIRQ; g++)
  begin : g_det
    assign trig_if[g].level  = sync2_q[g];
    assign trig_if[g].mode   = ctl_q[g][PCM_TRIG_LSB +: PCM_TRIG_W];
    assign trig_if[g].irq_en = ctl_q[g][PCM_IEN_IRQ_BIT];
    assign evt[g]            = trig_if[g].evt;
    pcm_trig_det u_det (
      .clk     (clk),
      .reset_n (reset_n),
      .trig    (trig_if[g])
    );
  end

  // ==========================================================================
  // bus write path
  assign awready  = ~aw_full_q;
  assign wready   = ~w_full_q;
  assign do_write = aw_full_q & w_full_q & ~bvalid_q;

  always_comb
  begin
    logic hit;
    hit       = 1'b0;
    aw_full_d = aw_full_q;
    aw_addr_d = aw_addr_q;
    w_full_d  = w_full_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    for (int i = 0; i < PCM_NIRQ; i++)
      ctl_d[i] = ctl_q[i];
    ana_d     = ana_q;
    pend_d    = pend_q;
    if (awvalid && awready)
    begin
      aw_full_d = 1'b1;
      aw_addr_d = {awaddr[PCM_AW-1:2], 2'b00};
    end
    if (wvalid && wready)
    begin
      w_full_d = 1'b1;
      w_data_d = wdata;
      w_strb_d = wstrb;
    end
    if (bvalid_q && bready)
      bvalid_d = 1'b0;
    if (do_write)
    begin
      for (int i = 0; i < PCM_NIRQ; i++)
        if (aw_addr_q == PCM_IRQ_OFF[i])
        begin
          hit      = 1'b1;
          ctl_d[i] = merge(ctl_q[i], w_data_q, w_strb_q) & PCM_IRQ_WMASK;
        end
      if (aw_addr_q == PCM_OFF_PIN64)
      begin
        hit   = 1'b1;
        ana_d = merge(ana_q, w_data_q, w_strb_q) & PCM_ANA_WMASK;
      end
      if (aw_addr_q == PCM_OFF_PEND)
      begin
        hit = 1'b1;
        if (w_strb_q[0])
          pend_d = pend_q & ~w_data_q[PCM_NIRQ-1:0];
      end
      if (aw_addr_q == PCM_OFF_LEVEL)
        hit = 1'b1;
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = hit ? PCM_RESP_OKAY : PCM_RESP_SLVERR;
    end
    pend_d = pend_d | evt;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_full_q  <= 1'b0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= PCM_RESP_OKAY;
      for (int i = 0; i < PCM_NIRQ; i++)
        ctl_q[i] <= PCM_IRQ_RST;
      ana_q     <= PCM_ANA_RST;
      pend_q    <= '0;
    end
    else
    begin
      aw_full_q <= aw_full_d;
      aw_addr_q <= aw_addr_d;
      w_full_q  <= w_full_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      for (int i = 0; i < PCM_NIRQ; i++)
        ctl_q[i] <= ctl_d[i];
      ana_q     <= ana_d;
      pend_q    <= pend_d;
    end
  end

  assign bvalid = bvalid_q;
  assign bresp  = bresp_q;

  // ==========================================================================
  // bus read path
  assign arready = ~rvalid_q;

  always_comb
  begin
    logic [PCM_AW-1:0] a;
    a        = {araddr[PCM_AW-1:2], 2'b00};
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (rvalid_q && rready)
      rvalid_d = 1'b0;
    if (arvalid && arready)
    begin
      rvalid_d = 1'b1;
      rdata_d  = '0;
      rresp_d  = PCM_RESP_SLVERR;
      for (int i = 0; i < PCM_NIRQ; i++)
        if (a == PCM_IRQ_OFF[i])
        begin
          rdata_d = ctl_q[i];
          rresp_d = PCM_RESP_OKAY;
        end
      if (a == PCM_OFF_PIN64)
      begin
        rdata_d = ana_q;
        rresp_d = PCM_RESP_OKAY;
      end
      if (a == PCM_OFF_PEND)
      begin
        rdata_d = {{(PCM_DW-PCM_NIRQ){1'b0}}, pend_q};
        rresp_d = PCM_RESP_OKAY;
      end
      if (a == PCM_OFF_LEVEL)
      begin
        rdata_d = {{(PCM_DW-PCM_NPIN){1'b0}}, sync2_q};
        rresp_d = PCM_RESP_OKAY;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= PCM_RESP_OKAY;
    end
    else
    begin
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
    end
  end

  assign rvalid = rvalid_q;
  assign rdata  = rdata_q;
  assign rresp  = rresp_q;

  // ==========================================================================
  // pad configuration outputs
  always_comb
  begin
    for (int i = 0; i < PCM_NIRQ; i++)
    begin
      legal[i] = PCM_LEGAL[i][ctl_q[i][PCM_FSEL_LSB +: PCM_FSEL_W]];
      pad_oe[i]           = ctl_q[i][PCM_OEN_BIT] & legal[i];
      pad_input_en[i]     = ctl_q[i][PCM_IEN_BIT];
      pullup_50k_en[i]    = ctl_q[i][PCM_PU50_BIT];
      pulldown_100k_en[i] = ctl_q[i][PCM_PD100_BIT];
      pullup_10k_en[i]    = ctl_q[i][PCM_PU10_BIT];
      drive_level[i]      = ctl_q[i][PCM_DRV_LSB +: PCM_DRV_W];
      schmitt_en[i]       = ctl_q[i][PCM_SMT_BIT];
      double_nmos_en[i]   = ctl_q[i][PCM_DNM_BIT];
      function_select[i]  = ctl_q[i][PCM_FSEL_LSB +: PCM_FSEL_W];
      irq_req[i] = pend_q[i] & ctl_q[i][PCM_MSK_BIT] & ctl_q[i][PCM_IEN_IRQ_BIT];
    end
    analog_sel                 = ana_q[PCM_ANA_BIT];
    pad_oe[PCM_ANA]            = ana_q[PCM_OEN_BIT] & ~ana_q[PCM_ANA_BIT];
    pad_input_en[PCM_ANA]      = ana_q[PCM_IEN_BIT];
    pullup_50k_en[PCM_ANA]     = ana_q[PCM_PU50_BIT];
    pulldown_100k_en[PCM_ANA]  = ana_q[PCM_PD100_BIT];
    pullup_10k_en[PCM_ANA]     = ana_q[PCM_PU10_BIT];
    drive_level[PCM_ANA]       = ana_q[PCM_DRV_LSB +: PCM_DRV_W];
    schmitt_en[PCM_ANA]        = ana_q[PCM_SMT_BIT];
  end

  // ==========================================================================
  // function routing, codes outside the pin's list route nothing
  always_comb
  begin
    logic [PCM_FSEL_W-1:0] c;
    c = '0;
    for (int i = 0; i < PCM_NIRQ; i++)
    begin
      c = ctl_q[i][PCM_FSEL_LSB +: PCM_FSEL_W];
      pad_out_d[i] = 1'b0;
      rx_sel_d[i]  = '0;
      rx_d[i]      = 1'b0;
      if (c == '0)
        pad_out_d[i] = gpio_out[i];
      else if (legal[i])
      begin
        pad_out_d[i] = periph_tx[i][c];
        if (ctl_q[i][PCM_IEN_BIT])
        begin
          rx_sel_d[i][c] = 1'b1;
          rx_d[i]        = sync2_q[i];
        end
      end
      gpio_in_d[i] = (c == '0) & ctl_q[i][PCM_IEN_BIT] & sync2_q[i];
    end
    pad_out_d[PCM_ANA] = ~ana_q[PCM_ANA_BIT] & gpio_out[PCM_ANA];
    gpio_in_d[PCM_ANA] = ~ana_q[PCM_ANA_BIT] & ana_q[PCM_IEN_BIT] & sync2_q[PCM_ANA];
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pad_out_q <= '0;
      gpio_in_q <= '0;
      rx_sel_q  <= '0;
      rx_q      <= '0;
    end
    else
    begin
      pad_out_q <= pad_out_d;
      gpio_in_q <= gpio_in_d;
      rx_sel_q  <= rx_sel_d;
      rx_q      <= rx_d;
    end
  end

  assign pad_out       = pad_out_q;
  assign gpio_in       = gpio_in_q;
  assign periph_rx_sel = rx_sel_q;
  assign periph_rx     = rx_q;

endmodule
`default_nettype wire

// ---- verilog/pcm_trig_det.sv ----
// Purpose: trigger event detector for one interruptible pin
// Assumes: level is already synchronised to clk
// Notes:   level modes fire every cycle the level holds
`timescale 1ns/1ps
`default_nettype none
module pcm_trig_det (
  input  wire logic clk,     // block clock
  input  wire logic reset_n, // async reset, active low
  pcm_trig_if.det   trig     // trigger setup and event
);
  import pcm_pkg::*;

  logic prev_q;
  logic prev_d;
  logic hit;

  // ==========================================================================
  // previous level
  always_comb
  begin
    prev_d = trig.level;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      prev_q <= 1'b0;
    else
      prev_q <= prev_d;
  end

  // ==========================================================================
  // event decode
  always_comb
  begin
    case (trig.mode)
      PCM_TRIG_RISE: hit = trig.level & ~prev_q;
      PCM_TRIG_FALL: hit = ~trig.level & prev_q;
      PCM_TRIG_BOTH: hit = trig.level ^ prev_q;
      PCM_TRIG_HIGH: hit = trig.level;
      PCM_TRIG_LOW:  hit = ~trig.level;
      default:       hit = 1'b0;
    endcase
    trig.evt = hit & trig.irq_en;
  end

endmodule
`default_nettype wire

// ---- verilog/pcm_trig_if.sv ----
// Purpose: carries one pin's trigger setup and its detected event
// Assumes: driven and sampled on the block clock
// Notes:   one instance per interruptible pin
`timescale 1ns/1ps
`default_nettype none
interface pcm_trig_if;
  import pcm_pkg::*;
  logic                  level;
  logic [PCM_TRIG_W-1:0] mode;
  logic                  irq_en;
  logic                  evt;
  modport det (input level, input mode, input irq_en, output evt);
  modport ctl (output level, output mode, output irq_en, input evt);
endinterface
`default_nettype wire
